// [design/ppi_pkg.sv]
// Package: register map, field layout and reset values of the port pin integration block
package ppi_pkg;
    // ------------------------------------------------------------
    // Register word indices (printed offsets not all multiples of 4: byte address is index * 4)
    // ------------------------------------------------------------
    localparam logic [11:0] PPI_IDX_PORT_D_OUT     = 12'h005;
    localparam logic [11:0] PPI_IDX_PORT_C_DIR     = 12'h006;
    localparam logic [11:0] PPI_IDX_PORT_D_DIR     = 12'h007;
    localparam logic [11:0] PPI_IDX_RSVD_LO_FIRST  = 12'h008;
    localparam logic [11:0] PPI_IDX_RSVD_LO_LAST   = 12'h019;
    localparam logic [11:0] PPI_IDX_PORT_A_SAMPLE  = 12'h120;
    localparam logic [11:0] PPI_IDX_RSVD_AFTER     = 12'h121;
    localparam logic [11:0] PPI_IDX_PORT_A_WEAK    = 12'h122;
    localparam logic [11:0] PPI_IDX_LINK_CTRL      = 12'h123;
    localparam logic [11:0] PPI_IDX_PORT_C_SAMPLE  = 12'h124;
    localparam logic [11:0] PPI_IDX_PORT_D_SAMPLE  = 12'h125;
    localparam int          PPI_ADDR_W             = 14;
    // ------------------------------------------------------------
    // Widths, fields and reset values
    // ------------------------------------------------------------
    localparam int          PPI_PD_W               = 8;
    localparam int          PPI_PC_W               = 2;
    localparam int          PPI_PA_W               = 6;
    localparam int          PPI_NARROW_W           = 4;
    localparam int          PPI_PC_INT_BIT         = 1;
    localparam int          PPI_PC_CLK_BIT         = 0;
    localparam int          PPI_CTRL_EN_BIT        = 0;
    localparam int          PPI_CTRL_WIDE_BIT      = 1;
    localparam logic [7:0]  PPI_RST_PORT_D_OUT     = 8'h00;
    localparam logic [7:0]  PPI_RST_DIR            = 8'h00;
    localparam logic [7:0]  PPI_RST_WEAK           = 8'h00;
    localparam logic [1:0]  PPI_RST_LINK_CTRL      = 2'h0;
    localparam int          PPI_SYNC_STAGES        = 2;
endpackage

// [design/ppi_sync.sv]
// Two-stage synchroniser for a bus of pin levels
`timescale 1ns/10ps
module ppi_sync #(
    parameter int W = 8
) (
    input  wire logic         i_mclk,
    input  wire logic         i_nrst,
    input  wire logic         i_ce,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // No reset on purpose: sampled levels are unaffected by reset
    always_ff @(posedge i_mclk) begin
        if (i_ce) begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;
endmodule

// [design/ppi_top.sv]
// Port pin integration: ports D, C and A pin muxing with APB register access
//
// Register access over APB was decided locally.
`timescale 1ns/10ps
module ppi_top
    import ppi_pkg::*;
#(
    parameter int PD_W = PPI_PD_W,
    parameter int PC_W = PPI_PC_W,
    parameter int PA_W = PPI_PA_W
) (
    input  wire logic                  i_mclk,
    input  wire logic                  i_nrst,
    input  wire logic                  i_ce,
    // APB slave
    input  wire logic                  i_psel,
    input  wire logic                  i_penable,
    input  wire logic                  i_pwrite,
    input  wire logic [PPI_ADDR_W-1:0] i_paddr,
    input  wire logic [31:0]           i_pwdata,
    output logic      [31:0]           o_prdata,
    output logic                       o_pready,
    output logic                       o_pslverr,
    // Port D pins
    input  wire logic [PD_W-1:0]       i_pd_pin,
    output logic      [PD_W-1:0]       o_pd_out,
    output logic      [PD_W-1:0]       o_pd_oe,
    output logic      [PD_W-1:0]       o_pd_pulldown,
    // Port C pins
    input  wire logic [PC_W-1:0]       i_pc_pin,
    output logic      [PC_W-1:0]       o_pc_out,
    output logic      [PC_W-1:0]       o_pc_oe,
    output logic      [PC_W-1:0]       o_pc_pulldown,
    // Port A pins (data and direction come from the neighbouring logic)
    input  wire logic [PA_W-1:0]       i_pa_pin,
    input  wire logic [PA_W-1:0]       i_pa_oe,
    output logic      [PA_W-1:0]       o_pa_weak,
    // Inter-die link peripheral side
    input  wire logic [PD_W-1:0]       i_link_data_out,
    input  wire logic [PD_W-1:0]       i_link_data_oe,
    output logic      [PD_W-1:0]       o_link_data_in,
    input  wire logic                  i_link_clock_out,
    output logic                       o_link_interrupt_in,
    output logic                       o_link_enabled,
    output logic                       o_link_wide
);
    // ------------------------------------------------------------
    // Synchronised pin levels
    // ------------------------------------------------------------
    localparam int SYN_W = PD_W + PC_W + PA_W;

    logic [SYN_W-1:0] pin_sync;
    logic [PD_W-1:0]  pd_sync;
    logic [PC_W-1:0]  pc_sync;
    logic [PA_W-1:0]  pa_sync;

    ppi_sync #(
        .W (SYN_W)
    ) u_sync (
        .i_mclk  (i_mclk),
        .i_nrst  (i_nrst),
        .i_ce    (i_ce),
        .i_async ({i_pa_pin, i_pc_pin, i_pd_pin}),
        .o_sync  (pin_sync)
    );

    assign pd_sync = pin_sync[PD_W-1:0];
    assign pc_sync = pin_sync[PD_W+PC_W-1:PD_W];
    assign pa_sync = pin_sync[SYN_W-1:PD_W+PC_W];

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [PD_W-1:0] port_d_out_latch_r;
    logic [PD_W-1:0] port_d_direction_r;
    logic [PC_W-1:0] port_c_direction_r;
    logic [PA_W-1:0] port_a_weak_drive_r;
    logic [1:0]      link_ctrl_r;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire        wr_acc     = i_psel & i_penable & i_pwrite & i_ce;
    wire [11:0] reg_idx    = i_paddr[PPI_ADDR_W-1:2];
    wire        aligned    = (i_paddr[1:0] == 2'h0);
    wire        hit_pd_out = aligned & (reg_idx == PPI_IDX_PORT_D_OUT);
    wire        hit_pc_dir = aligned & (reg_idx == PPI_IDX_PORT_C_DIR);
    wire        hit_pd_dir = aligned & (reg_idx == PPI_IDX_PORT_D_DIR);
    wire        hit_pa_smp = aligned & (reg_idx == PPI_IDX_PORT_A_SAMPLE);
    wire        hit_weak   = aligned & (reg_idx == PPI_IDX_PORT_A_WEAK);
    wire        hit_ctrl   = aligned & (reg_idx == PPI_IDX_LINK_CTRL);
    wire        hit_pc_smp = aligned & (reg_idx == PPI_IDX_PORT_C_SAMPLE);
    wire        hit_pd_smp = aligned & (reg_idx == PPI_IDX_PORT_D_SAMPLE);
    wire        hit_rsvd   = aligned & (((reg_idx >= PPI_IDX_RSVD_LO_FIRST) & (reg_idx <= PPI_IDX_RSVD_LO_LAST))
                                       | (reg_idx == PPI_IDX_RSVD_AFTER));
    wire        hit_any    = hit_pd_out | hit_pc_dir | hit_pd_dir | hit_pa_smp | hit_weak
                           | hit_ctrl | hit_pc_smp | hit_pd_smp | hit_rsvd;

    // ------------------------------------------------------------
    // Link ownership of pins
    // ------------------------------------------------------------
    logic [PD_W-1:0] pd_link_own;
    wire             link_en   = link_ctrl_r[PPI_CTRL_EN_BIT];
    wire             link_wide = link_ctrl_r[PPI_CTRL_WIDE_BIT];

    genvar g;
    generate
        for (g = 0; g < PD_W; g++) begin : g_pd_own
            // Narrow mode leaves the upper pins to GPIO
            assign pd_link_own[g] = link_en & (link_wide | (g < PPI_NARROW_W));
        end
    endgenerate

    // ------------------------------------------------------------
    // Port D pins
    // ------------------------------------------------------------
    assign o_pd_oe = (pd_link_own & i_link_data_oe)
                   | (~pd_link_own & port_d_direction_r);
    assign o_pd_out = (pd_link_own & i_link_data_out)
                    | (~pd_link_own & port_d_direction_r & port_d_out_latch_r);
    assign o_pd_pulldown  = pd_link_own & ~i_link_data_oe;
    // Raw pin goes to the link; the link does its own sampling
    assign o_link_data_in = pd_link_own & i_pd_pin;

    // ------------------------------------------------------------
    // Port C pins: 1 is link interrupt input, 0 is link clock output
    // ------------------------------------------------------------
    logic [PC_W-1:0] pc_link_oe;

    assign pc_link_oe = PC_W'(1 << PPI_PC_CLK_BIT);
    assign o_pc_oe = link_en ? pc_link_oe : port_c_direction_r;
    // Port C data latch lives next door; GPIO data here stays low
    assign o_pc_out = link_en ? PC_W'(i_link_clock_out << PPI_PC_CLK_BIT) : {PC_W{1'b0}};
    assign o_pc_pulldown = link_en ? PC_W'(1 << PPI_PC_INT_BIT) : {PC_W{1'b0}};
    // Synchronised copy so the link never sees a metastable level
    assign o_link_interrupt_in = link_en & pc_sync[PPI_PC_INT_BIT];

    // ------------------------------------------------------------
    // Port A drive strength
    // ------------------------------------------------------------
    assign o_pa_weak = port_a_weak_drive_r & i_pa_oe;

    assign o_link_enabled = link_en;
    assign o_link_wide    = link_wide;

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    logic [PD_W-1:0] pd_read;
    logic [31:0]     rd_mux;

    assign pd_read = (port_d_direction_r & port_d_out_latch_r)
                   | (~port_d_direction_r & pd_sync);

    assign rd_mux = hit_pd_out ? 32'(pd_read)
                  : hit_pc_dir ? 32'(port_c_direction_r)
                  : hit_pd_dir ? 32'(port_d_direction_r)
                  : hit_pa_smp ? 32'(pa_sync)
                  : hit_weak   ? 32'(port_a_weak_drive_r)
                  : hit_ctrl   ? 32'(link_ctrl_r)
                  : hit_pc_smp ? 32'(pc_sync)
                  : hit_pd_smp ? 32'(pd_sync)
                  : 32'h0000_0000;

    // Zero-wait slave: answer in the first access cycle
    assign o_pready  = 1'b1;
    assign o_pslverr = i_psel & i_penable & ~hit_any;

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            port_d_out_latch_r <= PD_W'(PPI_RST_PORT_D_OUT);
        end else if (wr_acc & hit_pd_out) begin
            port_d_out_latch_r <= i_pwdata[PD_W-1:0];
        end
    end

    // Direction bits change only by software, never by the link
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            port_d_direction_r <= PD_W'(PPI_RST_DIR);
            port_c_direction_r <= PC_W'(PPI_RST_DIR);
        end else if (wr_acc) begin
            if (hit_pd_dir) begin
                port_d_direction_r <= i_pwdata[PD_W-1:0];
            end
            if (hit_pc_dir) begin
                port_c_direction_r <= i_pwdata[PC_W-1:0];
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            port_a_weak_drive_r <= PA_W'(PPI_RST_WEAK);
            link_ctrl_r         <= PPI_RST_LINK_CTRL;
        end else if (wr_acc) begin
            if (hit_weak) begin
                port_a_weak_drive_r <= i_pwdata[PA_W-1:0];
            end
            if (hit_ctrl) begin
                link_ctrl_r <= i_pwdata[1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Read data register
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_prdata <= 32'h0000_0000;
        end else if (i_ce & i_psel & ~i_penable & ~i_pwrite) begin
            o_prdata <= rd_mux;
        end
    end
endmodule

// [test/ppi_monitor.sv]
// Checker: port level relations of the port pin integration block
`timescale 1ns/10ps
module ppi_monitor
    import ppi_pkg::*;
(
    input wire logic                  i_mclk,
    input wire logic                  i_nrst,
    input wire logic                  i_ce,
    input wire logic                  i_psel,
    input wire logic                  i_penable,
    input wire logic                  i_pwrite,
    input wire logic [PPI_ADDR_W-1:0] i_paddr,
    input wire logic [31:0]           o_prdata,
    input wire logic                  o_pslverr,
    input wire logic [PPI_PD_W-1:0]   i_pd_pin,
    input wire logic [PPI_PD_W-1:0]   o_pd_oe,
    input wire logic [PPI_PD_W-1:0]   o_pd_pulldown,
    input wire logic [PPI_PC_W-1:0]   i_pc_pin,
    input wire logic [PPI_PC_W-1:0]   o_pc_oe,
    input wire logic [PPI_PC_W-1:0]   o_pc_pulldown,
    input wire logic [PPI_PA_W-1:0]   i_pa_oe,
    input wire logic [PPI_PA_W-1:0]   o_pa_weak,
    input wire logic [PPI_PD_W-1:0]   i_link_data_oe,
    input wire logic [PPI_PD_W-1:0]   o_link_data_in,
    input wire logic                  o_link_interrupt_in,
    input wire logic                  o_link_enabled,
    input wire logic                  o_link_wide
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    wire logic [11:0]         idx = i_paddr[13:2];
    wire logic [PPI_PD_W-1:0] own = o_link_enabled ? (o_link_wide ? 8'hFF : 8'h0F) : 8'h00;
    wire logic                rsvd = i_paddr[1:0] == 2'h0 && (idx == PPI_IDX_RSVD_AFTER
                                     || (idx >= PPI_IDX_RSVD_LO_FIRST && idx <= PPI_IDX_RSVD_LO_LAST));
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_pd_own_oe; (o_pd_oe & own) == (i_link_data_oe & own); endproperty
    a_pd_own_oe: assert property (p_pd_own_oe) else $error("owned pin direction wrong");
    property p_pd_pull; o_pd_pulldown == (own & ~i_link_data_oe); endproperty
    a_pd_pull: assert property (p_pd_pull) else $error("pull-down wrong");
    property p_link_in; o_link_data_in == (i_pd_pin & own); endproperty
    a_link_in: assert property (p_link_in) else $error("link data in wrong");
    property p_pc_link; o_link_enabled |-> o_pc_oe == 2'h1 && o_pc_pulldown == 2'h2; endproperty
    a_pc_link: assert property (p_pc_link) else $error("port c link use wrong");
    property p_gpio_nopull; !o_link_enabled |-> o_pc_pulldown == 2'h0 && o_pd_pulldown == 8'h00; endproperty
    a_gpio_nopull: assert property (p_gpio_nopull) else $error("pull-down in gpio use");
    property p_weak; (o_pa_weak & ~i_pa_oe) == 6'h00; endproperty
    a_weak: assert property (p_weak) else $error("reduced drive on input");
    property p_rsvd; i_psel && i_penable && !i_pwrite && rsvd |-> o_prdata == 32'h0 && !o_pslverr; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved read not zero");
    // Two flops in the path, so the pin shows exactly two edges late
    property p_int_sync;
        (o_link_enabled && i_ce)[*3] |-> o_link_interrupt_in == $past(i_pc_pin[PPI_PC_INT_BIT], 2);
    endproperty
    a_int_sync: assert property (p_int_sync) else $error("interrupt sync latency wrong");
    c_wide: cover property (o_link_enabled && o_link_wide);
    c_narrow: cover property (o_link_enabled && !o_link_wide);
    c_rsvd: cover property (i_psel && i_penable && rsvd);
endmodule

// [test/ppi_pin_model.sv]
// Pad model: design drivers, external drivers, pull-downs and shorts
`timescale 1ns/10ps
module ppi_pin_model #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] i_out,
    input  wire logic [W-1:0] i_oe,
    input  wire logic [W-1:0] i_pull,
    input  wire logic [W-1:0] i_ext,
    input  wire logic [W-1:0] i_ext_en,
    input  wire logic [W-1:0] i_short,
    output logic      [W-1:0] o_pin
);
    // Short wins; a floating unpulled pad reads the inverse of the idle external value
    assign o_pin = ~i_short & ((i_oe & i_out) | (~i_oe & i_ext_en & i_ext)
                   | (~i_oe & ~i_ext_en & ~i_pull & ~i_ext));
endmodule

// [test/tb_top.sv]
// Testbench: register and pin checks of the port pin integration block
`timescale 1ns/10ps
module tb_top;
    import ppi_pkg::*;
    logic i_mclk = 0, i_nrst = 0, i_ce = 1, psel = 0, penable = 0, pwrite = 0, lk_clk = 0;
    logic [13:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [7:0] pd_pin, pd_out, pd_oe, pd_pd, pd_ext = 8'hA5, pd_en = 8'hFF, lk_out = 8'h5A, lk_oe = 8'h33, lk_in, own;
    logic [1:0] pc_pin, pc_out, pc_oe, pc_pd, pc_en = 2'h0, pc_ext = 2'h0;
    logic [5:0] pa_pin, pa_oe = '0, pa_weak, pa_out = 6'h2B, pa_ext = 6'h15, pa_sh = 6'h01;
    logic pready, pslverr, lk_int, lk_en, lk_wide;
    logic [11:0] rs [4] = '{12'h008, 12'h00C, 12'h019, 12'h121};
    int fails = 0, n_checks = 0, cyc = 0;
    ppi_top uut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_ce(i_ce), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_pd_pin(pd_pin), .o_pd_out(pd_out), .o_pd_oe(pd_oe), .o_pd_pulldown(pd_pd),
        .i_pc_pin(pc_pin), .o_pc_out(pc_out), .o_pc_oe(pc_oe), .o_pc_pulldown(pc_pd), .i_pa_pin(pa_pin),
        .i_pa_oe(pa_oe), .o_pa_weak(pa_weak), .i_link_data_out(lk_out), .i_link_data_oe(lk_oe),
        .o_link_data_in(lk_in), .i_link_clock_out(lk_clk), .o_link_interrupt_in(lk_int),
        .o_link_enabled(lk_en), .o_link_wide(lk_wide));
    ppi_pin_model #(.W(8)) u_pd (.i_out(pd_out), .i_oe(pd_oe), .i_pull(pd_pd), .i_ext(pd_ext),
        .i_ext_en(pd_en), .i_short(8'h00), .o_pin(pd_pin));
    ppi_pin_model #(.W(2)) u_pc (.i_out(pc_out), .i_oe(pc_oe), .i_pull(pc_pd), .i_ext(pc_ext),
        .i_ext_en(pc_en), .i_short(2'h0), .o_pin(pc_pin));
    // Port A pad starts with pin 0 shorted low, so the port A sample reads it low while it is driven high
    ppi_pin_model #(.W(6)) u_pa (.i_out(pa_out), .i_oe(pa_oe), .i_pull(6'h00), .i_ext(pa_ext),
        .i_ext_en(~pa_oe), .i_short(pa_sh), .o_pin(pa_pin));
    initial forever #2 i_mclk = ~i_mclk;
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task close_out;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] d);
        psel <= 1;
        pwrite <= wr;
        paddr <= {idx, 2'h0};
        pwdata <= d;
        @(posedge i_mclk) penable <= 1;
        do @(posedge i_mclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 0;
        penable <= 0;
        @(posedge i_mclk);
    endtask
    task rdchk(input logic [11:0] idx, input logic [31:0] exp);
        apb(0, idx, 32'h0);
        chk(rd, exp);
    endtask
    task w(input int n);
        repeat (n) @(posedge i_mclk);
    endtask
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            close_out();
        end
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        w(10);
        i_nrst <= 1;
        w(1);
        apb(1, PPI_IDX_PORT_D_DIR, 32'hFF);
        rdchk(PPI_IDX_PORT_D_OUT, 32'h00);
        apb(1, PPI_IDX_PORT_D_DIR, 32'h00);
        apb(1, PPI_IDX_PORT_D_OUT, 32'h3C);
        chk(32'(pd_oe), 32'h00);
        rdchk(PPI_IDX_PORT_D_OUT, 32'hA5);
        apb(1, PPI_IDX_PORT_D_DIR, 32'h0F);
        w(3);
        rdchk(PPI_IDX_PORT_D_OUT, 32'hAC);
        chk(32'(pd_out & pd_oe), 32'h0C);
        $display("gpio test done");
        foreach (rs[i]) begin
            apb(1, rs[i], 32'hFFFFFFFF);
            rdchk(rs[i], 32'h0);
        end
        $display("reserved test done");
        pa_oe <= 6'h3F;
        apb(1, PPI_IDX_PORT_A_SAMPLE, 32'h0);
        rdchk(PPI_IDX_PORT_A_SAMPLE, 32'h2A);
        pa_sh <= 6'h00;
        pa_out <= 6'h15;
        w(3);
        rdchk(PPI_IDX_PORT_A_SAMPLE, 32'h15);
        apb(1, PPI_IDX_PORT_A_WEAK, 32'h3F);
        pa_oe <= 6'h0F;
        w(1);
        chk(32'(pa_weak), 32'h0F);
        i_ce <= 0;
        apb(1, PPI_IDX_PORT_A_WEAK, 32'h0);
        i_ce <= 1;
        w(1);
        chk(32'(pa_weak), 32'h0F);
        pa_oe <= 6'h00;
        pa_ext <= 6'h2A;
        w(3);
        rdchk(PPI_IDX_PORT_A_SAMPLE, 32'h2A);
        i_nrst <= 0;
        w(2);
        i_nrst <= 1;
        w(1);
        rdchk(PPI_IDX_PORT_A_SAMPLE, 32'h2A);
        $display("port a test done");
        pd_en <= 8'h00;
        apb(1, PPI_IDX_PORT_D_OUT, 32'hC3);
        apb(1, PPI_IDX_PORT_D_DIR, 32'hF0);
        apb(1, PPI_IDX_PORT_C_DIR, 32'h2);
        for (int m = 1; m <= 3; m += 2) begin
            apb(1, PPI_IDX_LINK_CTRL, 32'(m));
            own = m[1] ? 8'hFF : 8'h0F;
            w(3);
            chk(32'(lk_in), 32'(own & 8'h12));
            chk(32'(pd_oe), 32'((own & 8'h33) | (~own & 8'hF0)));
            chk(32'(pd_pd), 32'(own & 8'hCC));
            rdchk(PPI_IDX_PORT_D_OUT, 32'hC2);
            rdchk(PPI_IDX_PORT_D_DIR, 32'hF0);
            rdchk(PPI_IDX_PORT_C_DIR, 32'h2);
        end
        lk_oe <= 8'hFF;
        w(1);
        chk(32'(pd_oe), 32'hFF);
        pc_en <= 2'h2;
        pc_ext <= 2'h2;
        lk_clk <= 1;
        w(4);
        chk(32'(lk_int), 32'h1);
        chk(32'(pc_out[PPI_PC_CLK_BIT]), 32'h1);
        pc_en <= 2'h0;
        w(4);
        chk(32'(lk_int), 32'h0);
        $display("link test done");
        close_out();
    end
endmodule
bind ppi_top ppi_monitor u_mon (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_ce(i_ce), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
    .i_pd_pin(i_pd_pin), .o_pd_oe(o_pd_oe), .o_pd_pulldown(o_pd_pulldown), .i_pc_pin(i_pc_pin),
    .o_pc_oe(o_pc_oe), .o_pc_pulldown(o_pc_pulldown), .i_pa_oe(i_pa_oe), .o_pa_weak(o_pa_weak),
    .i_link_data_oe(i_link_data_oe), .o_link_data_in(o_link_data_in),
    .o_link_interrupt_in(o_link_interrupt_in), .o_link_enabled(o_link_enabled), .o_link_wide(o_link_wide));
